//--- hdl/dlisb_regs.svh
`ifndef DLISB_REGS_SVH
`define DLISB_REGS_SVH

// Header field values
`define DLISB_TABLE_ID      8'h3b
`define DLISB_RSVD2         2'h3
`define DLISB_VERSION_NUM   5'h00
`define DLISB_CUR_NEXT      1'h1
`define DLISB_SECT_NUM      8'h00
`define DLISB_LAST_SECT     8'h00
`define DLISB_PROTO_DISC    8'h11
`define DLISB_MSG_TYPE      8'h03
`define DLISB_MSG_ID        16'h1006
`define DLISB_ORIGINATOR    2'h2
`define DLISB_IDENT         15'h0000
`define DLISB_RSVD_BYTE     8'hff
`define DLISB_ADAPT_LEN     8'h00

// Length arithmetic
`define DLISB_SECT_LEN_MAX  12'hffd
`define DLISB_TRAIL_CRC     16'h0004
`define DLISB_TRAIL_CSUM    16'h0004
`define DLISB_TAIL_FIXED    16'h0011

// Stream geometry
`define DLISB_HDR_BYTES     5'h14
`define DLISB_IDX_LAST      5'h13
`define DLISB_IDX_ZERO      5'h00
`define DLISB_IDX_ONE       5'h01
`define DLISB_FIFO_WIDTH    8
`define DLISB_FIFO_DEPTH    32

`endif

//--- hdl/dlisb_pkg.sv
package dlisb_pkg;

   typedef struct packed {
      logic [7:0] data;
      logic       first;
      logic       last;
   } dlisb_beat_t;

   typedef struct packed {
      logic        crcSel;
      logic [15:0] bodyLen;
      logic [13:0] version;
   } dlisb_cfg_t;

   typedef enum logic [1:0] {
      DLISB_IDLE = 2'b00,
      DLISB_EMIT = 2'b01,
      DLISB_DONE = 2'b11
   } dlisb_state_t;

endpackage

//--- hdl/dlisb_fifo.sv
`timescale 1ns/100ps
`include "dlisb_regs.svh"

module dlisb_fifo #(
   parameter int WIDTH = `DLISB_FIFO_WIDTH,
   parameter int DEPTH = `DLISB_FIFO_DEPTH
) (
   // Clock and reset
   input  wire logic             clk_sys,
   input  wire logic             nrst,
   // Fill side
   input  wire logic             inValid,
   output logic                  inReady,
   input  wire logic [WIDTH-1:0] inData,
   // Drain side
   output logic                  outValid,
   input  wire logic             outReady,
   output logic [WIDTH-1:0]      outData
);

   localparam int AW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0]    wrPtr_ff;
   logic [AW-1:0]    rdPtr_ff;
   logic [AW:0]      count_ff;
   logic             push;
   logic             pop;

   assign inReady  = (count_ff != (AW+1)'(DEPTH));
   assign outValid = (count_ff != '0);
   assign outData  = mem[rdPtr_ff];
   assign push     = inValid & inReady;
   assign pop      = outValid & outReady;

   always_ff @(posedge clk_sys) begin
      if (push) begin
         mem[wrPtr_ff] <= inData;
      end
   end

   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         wrPtr_ff <= '0;
         rdPtr_ff <= '0;
         count_ff <= '0;
      end else begin
         if (push) begin
            wrPtr_ff <= wrPtr_ff + AW'(1);
         end
         if (pop) begin
            rdPtr_ff <= rdPtr_ff + AW'(1);
         end
         case ({push, pop})
            2'b10:   count_ff <= count_ff + (AW+1)'(1);
            2'b01:   count_ff <= count_ff - (AW+1)'(1);
            default: count_ff <= count_ff;
         endcase
      end
   end

endmodule // dlisb_fifo

//--- hdl/dlisb_builder.sv
`timescale 1ns/100ps
`include "dlisb_regs.svh"

// Summary of operation
// - Message travels in its own download section
// - Syntax bit picks checksum or CRC32 trailer
// - Private bit is inverse of syntax bit
// - Section length from extension to trailer, max 4093
// - Extension equals low transaction identifier bytes
// - Section version number always zero
// - Current/next bit always one
// - Section and last section numbers zero
// - Transaction identifier: originator, version, identification, update
// - Originator sub-field is binary 10
// - Version changes whenever scenario message updates
// - Identification sub-field all zeros
// - Update bit toggles on each content update
// - Adaptation length zero, no adaptation header
// - Message length counts bytes after it, no trailer
module dlisb_builder (
   // Clock and reset
   input  wire logic                clk_sys,
   input  wire logic                nrst,
   // Control
   input  wire logic                startReq,
   input  wire logic                contentUpdate,
   input  wire logic                scenarioUpdate,
   input  wire dlisb_pkg::dlisb_cfg_t cfgIn,
   // Status
   output logic                     busy,
   output logic                     lenError,
   output logic [13:0]              curVersion,
   output logic                     curUpdateBit,
   // Byte stream out
   output logic                     outValid,
   input  wire logic                outReady,
   output logic [7:0]               outData,
   output logic                     outFirst,
   output logic                     outLast
);

   //==========================================================
   // Field assembly
   //==========================================================
   dlisb_pkg::dlisb_state_t state_ff;
   dlisb_pkg::dlisb_state_t nxt_state;
   dlisb_pkg::dlisb_cfg_t   cfg_ff;
   logic [13:0]             version_ff;
   logic                    updBit_ff;
   logic [4:0]              idx_ff;
   logic                    busy_ff;
   logic                    lenError_ff;
   logic [31:0]             transId;
   logic [15:0]             sectLen;
   logic [16:0]             reqLen;
   logic                    lenBad;
   logic                    updSnap_ff;
   logic                    fifoInReady;
   logic                    fifoOutValid;
   logic [9:0]              fifoOutWord;
   logic                    pushBeat;
   dlisb_pkg::dlisb_beat_t  beat;
   logic                    outValid_ff;
   dlisb_pkg::dlisb_beat_t  outBeat_ff;
   logic                    takeOut;

   // Four sub-fields concatenated in order
   assign transId = {`DLISB_ORIGINATOR, cfg_ff.version, `DLISB_IDENT, updSnap_ff};

   // Extension, numbering and trailer, plus fixed tail, plus body
   assign sectLen = cfg_ff.bodyLen + `DLISB_TAIL_FIXED
                  + (cfg_ff.crcSel ? `DLISB_TRAIL_CRC : `DLISB_TRAIL_CSUM);
   // Refusal judged on the request itself, one bit wider so a huge body cannot wrap
   assign reqLen  = {1'b0, cfgIn.bodyLen} + {1'b0, `DLISB_TAIL_FIXED}
                  + {1'b0, (cfgIn.crcSel ? `DLISB_TRAIL_CRC : `DLISB_TRAIL_CSUM)};
   assign lenBad  = (reqLen > {5'h00, `DLISB_SECT_LEN_MAX});

   // Byte selector for the header; decoded for every emitted index
   function automatic logic [7:0] hdrByte(input logic [4:0] i, input logic crc,
                                          input logic [15:0] slen, input logic [31:0] tid,
                                          input logic [15:0] mlen);
      logic [7:0]  b;
      logic [15:0] msgId;
      b = 8'h00;
      msgId = `DLISB_MSG_ID;
      case (i)
         5'h00: b = `DLISB_TABLE_ID;
         5'h01: b = {crc, ~crc, `DLISB_RSVD2, slen[11:8]};
         5'h02: b = slen[7:0];
         5'h03: b = tid[15:8];
         5'h04: b = tid[7:0];
         5'h05: b = {`DLISB_RSVD2, `DLISB_VERSION_NUM, `DLISB_CUR_NEXT};
         5'h06: b = `DLISB_SECT_NUM;
         5'h07: b = `DLISB_LAST_SECT;
         5'h08: b = `DLISB_PROTO_DISC;
         5'h09: b = `DLISB_MSG_TYPE;
         5'h0a: b = msgId[15:8];
         5'h0b: b = msgId[7:0];
         5'h0c: b = tid[31:24];
         5'h0d: b = tid[23:16];
         5'h0e: b = tid[15:8];
         5'h0f: b = tid[7:0];
         5'h10: b = `DLISB_RSVD_BYTE;
         5'h11: b = `DLISB_ADAPT_LEN;
         5'h12: b = mlen[15:8];
         5'h13: b = mlen[7:0];
         default: b = 8'h00;
      endcase
      return b;
   endfunction

   assign beat.data  = hdrByte(idx_ff, cfg_ff.crcSel, sectLen, transId, cfg_ff.bodyLen);
   assign beat.first = (idx_ff == `DLISB_IDX_ZERO);
   assign beat.last  = (idx_ff == `DLISB_IDX_LAST);
   assign pushBeat   = (state_ff == dlisb_pkg::DLISB_EMIT) & fifoInReady;

   //==========================================================
   // Versioning state
   //==========================================================
   // Version moves on any scenario change, including this message
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         version_ff <= 14'h0000;
      end else if (scenarioUpdate | contentUpdate) begin
         version_ff <= version_ff + 14'h0001;
      end
   end

   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         updBit_ff <= 1'b0;
      end else if (contentUpdate) begin
         updBit_ff <= ~updBit_ff;
      end
   end

   //==========================================================
   // Sequencer
   //==========================================================
   always_comb begin
      nxt_state = state_ff;
      case (state_ff)
         dlisb_pkg::DLISB_IDLE: begin
            // Oversized sections are refused rather than truncated
            if (startReq && !lenBad) begin
               nxt_state = dlisb_pkg::DLISB_EMIT;
            end
         end
         dlisb_pkg::DLISB_EMIT: begin
            if (pushBeat && beat.last) begin
               nxt_state = dlisb_pkg::DLISB_DONE;
            end
         end
         dlisb_pkg::DLISB_DONE: begin
            nxt_state = dlisb_pkg::DLISB_IDLE;
         end
         default: nxt_state = dlisb_pkg::DLISB_IDLE;
      endcase
   end

   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         state_ff <= dlisb_pkg::DLISB_IDLE;
      end else begin
         state_ff <= nxt_state;
      end
   end

   // Config snapshot so a header never mixes two versions
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         cfg_ff     <= '0;
         updSnap_ff <= 1'b0;
      end else if (state_ff == dlisb_pkg::DLISB_IDLE && startReq) begin
         cfg_ff         <= cfgIn;
         cfg_ff.version <= version_ff;
         // Update bit frozen too, so extension and identifier agree
         updSnap_ff     <= updBit_ff;
      end
   end

   // One byte per accepted transfer
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         idx_ff <= `DLISB_IDX_ZERO;
      end else if (state_ff != dlisb_pkg::DLISB_EMIT) begin
         idx_ff <= `DLISB_IDX_ZERO;
      end else if (pushBeat) begin
         idx_ff <= idx_ff + `DLISB_IDX_ONE;
      end
   end

   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         busy_ff     <= 1'b0;
         lenError_ff <= 1'b0;
      end else begin
         busy_ff <= (nxt_state != dlisb_pkg::DLISB_IDLE) | fifoOutValid | outValid_ff;
         if (state_ff == dlisb_pkg::DLISB_IDLE && startReq) begin
            lenError_ff <= lenBad;
         end
      end
   end

   //==========================================================
   // Output buffering
   //==========================================================
   dlisb_fifo #(
      .WIDTH (10),
      .DEPTH (`DLISB_FIFO_DEPTH)
   ) u_fifo (
      .clk_sys  (clk_sys),
      .nrst     (nrst),
      .inValid  (state_ff == dlisb_pkg::DLISB_EMIT),
      .inReady  (fifoInReady),
      .inData   (beat),
      .outValid (fifoOutValid),
      .outReady (takeOut),
      .outData  (fifoOutWord)
   );

   // Output register holds under backpressure
   assign takeOut = fifoOutValid & (~outValid_ff | outReady);

   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         outValid_ff <= 1'b0;
         outBeat_ff  <= '0;
      end else if (~outValid_ff | outReady) begin
         outValid_ff <= fifoOutValid;
         if (fifoOutValid) begin
            outBeat_ff <= fifoOutWord;
         end
      end
   end

   assign outValid     = outValid_ff;
   assign outData      = outBeat_ff.data;
   assign outFirst     = outBeat_ff.first;
   assign outLast      = outBeat_ff.last;
   assign busy         = busy_ff;
   assign lenError     = lenError_ff;
   assign curVersion   = version_ff;
   assign curUpdateBit = updBit_ff;

endmodule // dlisb_builder

//--- verification/dlisb_builder_properties.sv
`timescale 1ns/100ps
module dlisb_builder_properties (
   // Clock and reset
   input wire logic        clk_sys,
   input wire logic        nrst,
   // Control and status
   input wire logic        contentUpdate,
   input wire logic        scenarioUpdate,
   input wire logic [13:0] curVersion,
   input wire logic        curUpdateBit,
   // Byte stream
   input wire logic        outValid,
   input wire logic        outReady,
   input wire logic [7:0]  outData,
   input wire logic        outFirst,
   input wire logic        outLast
);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!nrst);
   // =====================================
   // Byte position of the header on the wire
   logic [4:0] byteIdx_ff;
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) byteIdx_ff <= 5'h00;
      else if (outValid && outReady) byteIdx_ff <= outLast ? 5'h00 : byteIdx_ff + 5'h01;
   end
   sequence s_at(logic [4:0] n);
      outValid && byteIdx_ff == n;
   endsequence
   // =====================================
   // Properties
   property p_tableId; s_at(5'h00) |-> outFirst && outData == 8'h3b; endproperty
   a_tableId: assert property (p_tableId) else $error("bad first byte");
   property p_flags; s_at(5'h01) |-> outData[7] != outData[6] && outData[5:4] == 2'h3; endproperty
   a_flags: assert property (p_flags) else $error("bad flag byte");
   property p_verByte; s_at(5'h05) |-> outData == 8'hc1; endproperty
   a_verByte: assert property (p_verByte) else $error("bad version byte");
   property p_secNum; outValid && byteIdx_ff[4:1] == 4'h3 |-> outData == 8'h00; endproperty
   a_secNum: assert property (p_secNum) else $error("bad section number");
   property p_msgHdr; s_at(5'h08) |-> outData == 8'h11; endproperty
   a_msgHdr: assert property (p_msgHdr) else $error("bad discriminator");
   property p_origin; s_at(5'h0c) |-> outData[7:6] == 2'h2; endproperty
   a_origin: assert property (p_origin) else $error("bad originator");
   property p_rsvdByte; s_at(5'h10) |-> outData == 8'hff; endproperty
   a_rsvdByte: assert property (p_rsvdByte) else $error("bad reserved byte");
   property p_ident; s_at(5'h0e) |-> outData == 8'h00; endproperty
   a_ident: assert property (p_ident) else $error("bad identification");
   property p_adapt; s_at(5'h11) |-> outData == 8'h00; endproperty
   a_adapt: assert property (p_adapt) else $error("bad adaptation length");
   property p_lastIdx; outValid && outLast |-> byteIdx_ff == 5'h13 && !outFirst; endproperty
   a_lastIdx: assert property (p_lastIdx) else $error("bad last marker");
   property p_hold; outValid && !outReady |=> outValid && $stable(outData) && $stable(outLast); endproperty
   a_hold: assert property (p_hold) else $error("byte dropped under stall");
   property p_verInc; contentUpdate || scenarioUpdate |=> curVersion == $past(curVersion) + 14'h0001; endproperty
   a_verInc: assert property (p_verInc) else $error("version not bumped");
   property p_updTog; contentUpdate |=> curUpdateBit != $past(curUpdateBit); endproperty
   a_updTog: assert property (p_updTog) else $error("update bit not toggled");
endmodule // dlisb_builder_properties

bind dlisb_builder dlisb_builder_properties u_props (.clk_sys(clk_sys), .nrst(nrst),
   .contentUpdate(contentUpdate), .scenarioUpdate(scenarioUpdate), .curVersion(curVersion),
   .curUpdateBit(curUpdateBit), .outValid(outValid), .outReady(outReady), .outData(outData),
   .outFirst(outFirst), .outLast(outLast));

//--- verification/dlisb_sink.sv
`timescale 1ns/100ps
module dlisb_sink (
   // Clock and reset
   input  wire logic       clk_sys,
   input  wire logic       nrst,
   // Stream from the builder
   input  wire logic       valid,
   input  wire logic [7:0] data,
   input  wire logic       first,
   input  wire logic       last,
   output logic            ready,
   // Pacing
   input  wire logic       slowMode
);
   logic [7:0]  got[$];
   logic [1:0]  marks[$];
   logic [15:0] lfsr = 16'hace1;
   // Ready moves only off the sampling edge
   always @(negedge clk_sys) begin
      lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
      ready = !slowMode || lfsr[0];
   end
   always @(posedge clk_sys) begin
      if (nrst && valid && ready) begin
         got.push_back(data);
         marks.push_back({first, last});
      end
   end
endmodule // dlisb_sink

//--- verification/dlisb_builder_bench.sv
`timescale 1ns/100ps
module dlisb_builder_bench;
   logic clk_sys, nrst, startReq, contentUpdate, scenarioUpdate, slowMode;
   dlisb_pkg::dlisb_cfg_t cfgIn;
   logic busy, lenError, curUpdateBit, outValid, outReady, outFirst, outLast, expUpd;
   logic [13:0] curVersion, expVer;
   logic [7:0]  outData;
   logic [31:0] rs;
   int          err_total, checks_done;

   dlisb_builder DUT (.clk_sys(clk_sys), .nrst(nrst), .startReq(startReq), .contentUpdate(contentUpdate),
      .scenarioUpdate(scenarioUpdate), .cfgIn(cfgIn), .busy(busy), .lenError(lenError),
      .curVersion(curVersion), .curUpdateBit(curUpdateBit), .outValid(outValid), .outReady(outReady),
      .outData(outData), .outFirst(outFirst), .outLast(outLast));
   dlisb_sink sink (.clk_sys(clk_sys), .nrst(nrst), .valid(outValid), .data(outData), .first(outFirst),
      .last(outLast), .ready(outReady), .slowMode(slowMode));

   initial clk_sys = 1'b0;
   always #50 clk_sys = ~clk_sys;

   // =====================================
   // Helpers
   function automatic logic [31:0] xs(input logic [31:0] s);
      s = s ^ (s << 13);
      s = s ^ (s >> 17);
      return s ^ (s << 5);
   endfunction
   function automatic logic [7:0] hdrByte(input int i, input logic crc, input logic [15:0] len,
                                          input logic [13:0] ver, input logic upd);
      logic [7:0]  e[20];
      logic [15:0] sl;
      logic [31:0] tid;
      sl = len + 16'h0015;
      tid = {2'h2, ver, 15'h0000, upd};
      e = '{8'h3b, {crc, ~crc, 2'h3, sl[11:8]}, sl[7:0], tid[15:8], tid[7:0], 8'hc1, 8'h00, 8'h00,
            8'h11, 8'h03, 8'h10, 8'h06, tid[31:24], tid[23:16], tid[15:8], tid[7:0], 8'hff, 8'h00,
            len[15:8], len[7:0]};
      return e[i];
   endfunction
   task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
      checks_done++;
      if (seen !== exp) begin
         err_total++;
         $display("wrong value at %0t: %s seen %0h expected %0h", $time, msg, seen, exp);
      end
   endtask
   task automatic close_out;
      if (err_total == 0 && checks_done > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   // One header: update pulses, start, a stray start mid-frame, then compare
   task automatic frame(input logic crc, input logic [15:0] len, input logic [1:0] upd2);
      int n;
      @(negedge clk_sys) {scenarioUpdate, contentUpdate} = upd2;
      @(negedge clk_sys) {scenarioUpdate, contentUpdate} = 2'h0;
      if (upd2 != 2'h0) expVer = expVer + 14'h0001;
      if (upd2[0]) expUpd = ~expUpd;
      check(curVersion, expVer, "version");
      check(curUpdateBit, expUpd, "update bit");
      cfgIn = '{crcSel: crc, bodyLen: len, version: 14'h0};
      startReq = 1'b1;
      sink.got.delete();
      sink.marks.delete();
      @(negedge clk_sys) startReq = 1'b0;
      repeat (2) @(negedge clk_sys);
      startReq = 1'b1;
      @(negedge clk_sys) startReq = 1'b0;
      n = 0;
      while (busy === 1'b1 && n < 600) begin
         @(negedge clk_sys);
         n++;
      end
      check(busy, 1'b0, "busy stuck");
      if (len + 17'h00015 > 17'h00ffd) begin
         check(lenError, 1'b1, "long section taken");
         check(sink.got.size(), 0, "bytes from refused start");
      end else begin
         check(lenError, 1'b0, "length flag");
         check(sink.got.size(), 20, "header size");
         for (int i = 0; i < 20 && i < sink.got.size(); i++) begin
            check(sink.got[i], hdrByte(i, crc, len, expVer, expUpd), "header byte");
            check(sink.marks[i], {i == 0, i == 19}, "frame marker");
         end
      end
   endtask

   // =====================================
   // Main sequence
   initial begin
      {nrst, startReq, contentUpdate, scenarioUpdate, slowMode} = 5'h00;
      cfgIn = '0;
      {err_total, checks_done, expVer, expUpd} = '0;
      rs = 32'd87622;
      repeat (8) @(negedge clk_sys);
      nrst = 1'b1;
      check(outValid, 1'b0, "valid after reset");
      frame(1'b1, 16'h0000, 2'h0);
      slowMode = 1'b1;
      frame(1'b0, 16'h0fe8, 2'h1);
      frame(1'b1, 16'h0fe9, 2'h3);
      frame(1'b0, 16'h2000, 2'h2);
      frame(1'b1, 16'hfff0, 2'h1);
      // Reset again while idle: counters must restart
      @(negedge clk_sys) nrst = 1'b0;
      repeat (2) @(negedge clk_sys);
      nrst = 1'b1;
      {expVer, expUpd} = '0;
      check(curVersion, 14'h0000, "version after reset");
      check(curUpdateBit, 1'b0, "update bit after reset");
      check(outValid, 1'b0, "valid after second reset");
      for (int k = 0; k < 10; k++) begin
         rs = xs(rs);
         slowMode = rs[12];
         frame(rs[5], 16'(rs[31:16] % 4200), rs[9:8]);
      end
      close_out();
   end
   initial begin
      repeat (30000) @(posedge clk_sys);
      err_total++;
      close_out();
   end
endmodule // dlisb_builder_bench
